// ---- hdl/pmwic_pkg.sv ----
// Operation
// - Watchdog needs option and run bit; always counts
// - Watchdog time-out resets device, clears timeout flag
// - Base watchdog period chosen by option
// - Assigned prescaler lengthens time-out 1:1 to 1:128
// - Watchdog clear clears counter, prescaler; sets flag
// - Software interrupt vectors 0x001, clears global enable
// - Enable, disable, return instructions steer global enable
// - Flags sticky until written 0; read masked
// - Enabled pending flag vectors 0x008, clears enable
// - Timer overflow sets flag, served when enabled
// - Selected input pin change sets port flag
// - Selected edge on pin zero sets external flag
// - Clock select bit picks fast or slow clock
// - Instruction clock is system clock over 2 or 4
// - Startup option picks Normal or Slow after reset
// - Mode 10b enters Standby; fast oscillator kept unless stop bit set
// - Standby wakes on timer, port, external events
// - Sleep or mode 01b enters Halt, updates flags
// - Halt stops oscillators; wakes on port, external
// - Halt wake waits 16 clocks; Standby none
// - Wake vectors 0x008 only if globally enabled
package pmwic_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ       = 25;
    localparam int WDT_US_0      = 3500;
    localparam int WDT_US_1      = 15000;
    localparam int WDT_US_2      = 60000;
    localparam int WDT_US_3      = 250000;
    localparam int HALT_WAKE_CYC = 16;

    // ****************************************
    // Register word offsets (byte address)
    // ****************************************
    localparam logic [4:0] OFS_POWER_CONTROL_REG   = 5'h00;
    localparam logic [4:0] OFS_OSC    = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_INTERRUPT_ENABLE_REG   = 5'h0C;
    localparam logic [4:0] OFS_INTERRUPT_FLAG_REG   = 5'h10;
    localparam logic [4:0] OFS_PSCL   = 5'h14;
    localparam logic [4:0] OFS_WAKE   = 5'h18;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PC_WDT_RUN  = 7;
    localparam int PC_EXT_SEL  = 6;
    localparam int PC_EXT_EDGE = 5;
    localparam int OSC_HCS     = 0;
    localparam int OSC_STOP    = 1;
    localparam int OSC_MODE_LO = 2;
    localparam int ST_PD       = 3;
    localparam int ST_TO       = 4;
    localparam int ST_GIE      = 7;
    localparam int IRQ_TMR     = 0;
    localparam int IRQ_PORT    = 1;
    localparam int IRQ_EXT     = 2;
    localparam int PS_ASSIGN   = 3;

    // ****************************************
    // Encodings and reset values
    // ****************************************
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_HALT    = 2'h1;
    localparam logic [1:0] MODE_STANDBY = 2'h2;
    localparam logic [8:0] VEC_SOFT     = 9'h001;
    localparam logic [8:0] VEC_HW       = 9'h008;
    localparam logic       WDT_RUN_RST  = 1'b1;
    localparam logic [2:0] INTERRUPT_ENABLE_REG_RST     = 3'h0;
    localparam logic [5:0] WAKE_RST     = 6'h00;
    localparam logic [2:0] PSSEL_RST    = 3'h0;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_SLOW   = 3'b001,
        ST_STBY   = 3'b011,
        ST_HALT   = 3'b010,
        ST_WAKE   = 3'b110
    } pmwic_state_type;

endpackage

// ---- hdl/pmwic_top.sv ----
`timescale 1ns/1ps
module pmwic_top #(
    parameter int WDT_CYC_0 = pmwic_pkg::WDT_US_0 * pmwic_pkg::CLK_MHZ,
    parameter int WDT_CYC_1 = pmwic_pkg::WDT_US_1 * pmwic_pkg::CLK_MHZ,
    parameter int WDT_CYC_2 = pmwic_pkg::WDT_US_2 * pmwic_pkg::CLK_MHZ,
    parameter int WDT_CYC_3 = pmwic_pkg::WDT_US_3 * pmwic_pkg::CLK_MHZ
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [4:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0]  avsByteEnable,
    output logic      [31:0] avsReadData,
    output logic             avsWaitRequest,
    input  wire logic        cfgWdtEnable,
    input  wire logic [1:0]  cfgWdtPeriod,
    input  wire logic        cfgInstDiv4,
    input  wire logic        cfgStartHigh,
    input  wire logic        cmdWdtClear,
    input  wire logic        cmdEnableInt,
    input  wire logic        cmdDisableInt,
    input  wire logic        cmdRetIntr,
    input  wire logic        cmdSoftInt,
    input  wire logic        cmdSleep,
    input  wire logic        timerOverflow,
    input  wire logic [5:0]  portIsInput,
    input  wire logic [5:0]  portPin,
    output logic             vecStrobe,
    output logic      [8:0]  vecAddr,
    output logic             cpuRun,
    output logic             instTick,
    output logic             sysClkHigh,
    output logic             fastOscOn,
    output logic             slowOscOn,
    output logic             timerAllow,
    output logic             wdtResetPulse
);

    // ****************************************
    // State
    // ****************************************
    pmwic_pkg::pmwic_state_type state_r;
    pmwic_pkg::pmwic_state_type state_nxt;

    logic        strapDone_r;
    logic        cfgWdtEn_r;
    logic [1:0]  cfgWdtPer_r;
    logic        cfgDiv4_r;
    logic        cfgHigh_r;
    logic        wdtRun_r;
    logic        extSel_r;
    logic        extEdge_r;
    logic        hcs_r;
    logic        oscStop_r;
    logic [1:0]  modeField_r;
    logic        toFlag_r;
    logic        pdFlag_r;
    logic [2:0]  irqEn_r;
    logic [2:0]  irqFlag_r;
    logic        psAssign_r;
    logic [2:0]  psSel_r;
    logic [5:0]  wakeSel_r;
    logic        gie_r;
    logic [4:0]  waitCnt_r;
    logic [31:0] wdtCnt_r;
    logic [7:0]  psCnt_r;
    logic [1:0]  instDiv_r;
    logic [5:0]  pinMeta_r;
    logic [5:0]  pinSync_r;
    logic [5:0]  pinPrev_r;
    logic        waitReq_r;
    logic [31:0] readData_r;

    // ****************************************
    // Bus decode
    // ****************************************
    wire        busReq   = avsRead | avsWrite;
    wire        wrAcc    = avsWrite & ~waitReq_r & avsByteEnable[0];
    wire [7:0]  wd       = avsWriteData[7:0];
    wire        wrPcon   = wrAcc & (avsAddress == pmwic_pkg::OFS_POWER_CONTROL_REG);
    wire        wrOsc    = wrAcc & (avsAddress == pmwic_pkg::OFS_OSC);
    wire        wrInte   = wrAcc & (avsAddress == pmwic_pkg::OFS_INTERRUPT_ENABLE_REG);
    wire        wrIntf   = wrAcc & (avsAddress == pmwic_pkg::OFS_INTERRUPT_FLAG_REG);
    wire        wrPscl   = wrAcc & (avsAddress == pmwic_pkg::OFS_PSCL);
    wire        wrWake   = wrAcc & (avsAddress == pmwic_pkg::OFS_WAKE);
    wire [1:0]  wdMode   = wd[pmwic_pkg::OSC_MODE_LO +: 2];

    wire [7:0]  rdPcon   = {wdtRun_r, extSel_r, extEdge_r, 5'h00};
    wire [7:0]  rdOsc    = {4'h0, modeField_r, oscStop_r, hcs_r};
    wire [7:0]  rdStatus = {gie_r, 2'h0, toFlag_r, pdFlag_r, state_r};
    wire [7:0]  rdInte   = {5'h00, irqEn_r};
    wire [7:0]  rdIntf   = {5'h00, irqFlag_r & irqEn_r};
    wire [7:0]  rdPscl   = {4'h0, psAssign_r, psSel_r};
    wire [7:0]  rdWake   = {2'h0, wakeSel_r};
    wire [7:0]  rdSel    =
        (avsAddress == pmwic_pkg::OFS_POWER_CONTROL_REG)   ? rdPcon   :
        (avsAddress == pmwic_pkg::OFS_OSC)    ? rdOsc    :
        (avsAddress == pmwic_pkg::OFS_STATUS) ? rdStatus :
        (avsAddress == pmwic_pkg::OFS_INTERRUPT_ENABLE_REG)   ? rdInte   :
        (avsAddress == pmwic_pkg::OFS_INTERRUPT_FLAG_REG)   ? rdIntf   :
        (avsAddress == pmwic_pkg::OFS_PSCL)   ? rdPscl   :
        (avsAddress == pmwic_pkg::OFS_WAKE)   ? rdWake   : 8'h00;

    // Fixed two-cycle answer: waitrequest drops one cycle after the
    // request, and the request completes on the following edge
    wire        waitReq_nxt = ~(busReq & waitReq_r);

    // ****************************************
    // Pin events
    // ****************************************
    // Pin zero leaves change detection while it serves as the
    // external interrupt input
    wire [5:0]  chgMask  = wakeSel_r & portIsInput & {5'h1F, ~extSel_r};
    wire [5:0]  pinChg   = (pinSync_r ^ pinPrev_r) & chgMask;
    wire        portEvt  = |pinChg;
    wire        riseP0   = pinSync_r[0] & ~pinPrev_r[0];
    wire        fallP0   = ~pinSync_r[0] & pinPrev_r[0];
    wire        extEvt   = extSel_r & (extEdge_r ? riseP0 : fallP0);
    wire [2:0]  irqEvt   = {extEvt, portEvt, timerOverflow};

    // ****************************************
    // Watchdog
    // ****************************************
    wire        running  = (state_r == pmwic_pkg::ST_NORMAL) |
                           (state_r == pmwic_pkg::ST_SLOW);
    wire        wrHalt   = wrOsc & (wdMode == pmwic_pkg::MODE_HALT);
    wire        wrStby   = wrOsc & (wdMode == pmwic_pkg::MODE_STANDBY);
    wire        enterHalt = running & (cmdSleep | wrHalt);
    wire        enterStby = running & wrStby & ~enterHalt;
    wire        wdtOn    = cfgWdtEn_r & wdtRun_r;
    wire [31:0] wdtLimit =
        (cfgWdtPer_r == 2'd0) ? 32'(WDT_CYC_0) :
        (cfgWdtPer_r == 2'd1) ? 32'(WDT_CYC_1) :
        (cfgWdtPer_r == 2'd2) ? 32'(WDT_CYC_2) : 32'(WDT_CYC_3);
    wire [7:0]  psLimit  = psAssign_r ? (8'h01 << psSel_r) : 8'h01;
    wire        baseEnd  = wdtCnt_r == (wdtLimit - 32'd1);
    wire        psEnd    = psCnt_r == (psLimit - 8'h01);
    wire        wdtClr   = cmdWdtClear | enterHalt;
    wire        timeout  = wdtOn & baseEnd & psEnd & ~wdtClr;
    wire        psClr    = (cmdWdtClear & psAssign_r) | enterHalt |
                           ~psAssign_r | ~wdtOn | timeout;
    wire [31:0] wdtCnt_nxt = (wdtClr | ~wdtOn | baseEnd) ? 32'd0 :
                             wdtCnt_r + 32'd1;
    wire [7:0]  psCnt_nxt  = psClr ? 8'h00 :
                             (baseEnd ? psCnt_r + 8'h01 : psCnt_r);

    // ****************************************
    // Modes and wake-up
    // ****************************************
    wire        haltDone = (state_r == pmwic_pkg::ST_WAKE) &
                waitCnt_r == 5'(pmwic_pkg::HALT_WAKE_CYC - 1);
    wire        stbyWake = (state_r == pmwic_pkg::ST_STBY) &
                           (timerOverflow | portEvt | extEvt);
    wire        haltWake = (state_r == pmwic_pkg::ST_HALT) &
                           (portEvt | extEvt);
    wire        resume   = stbyWake | haltDone;
    wire pmwic_pkg::pmwic_state_type runState =
        hcs_r ? pmwic_pkg::ST_NORMAL : pmwic_pkg::ST_SLOW;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pmwic_pkg::ST_NORMAL,
            pmwic_pkg::ST_SLOW: begin
                if (enterHalt) begin
                    state_nxt = pmwic_pkg::ST_HALT;
                end else if (enterStby) begin
                    state_nxt = pmwic_pkg::ST_STBY;
                end else begin
                    state_nxt = runState;
                end
            end
            pmwic_pkg::ST_STBY: begin
                if (stbyWake) begin
                    state_nxt = runState;
                end
            end
            pmwic_pkg::ST_HALT: begin
                if (haltWake) begin
                    state_nxt = pmwic_pkg::ST_WAKE;
                end
            end
            pmwic_pkg::ST_WAKE: begin
                if (haltDone) begin
                    state_nxt = runState;
                end
            end
            default: begin
                state_nxt = runState;
            end
        endcase
        if (timeout) begin
            state_nxt = cfgHigh_r ? pmwic_pkg::ST_NORMAL : pmwic_pkg::ST_SLOW;
        end
    end

    // ****************************************
    // Interrupt control
    // ****************************************
    wire        swInt    = running & cmdSoftInt;
    wire        hwPend   = |(irqFlag_r & irqEn_r);
    wire        hwTake   = running & gie_r & hwPend & ~swInt & ~enterHalt &
                           ~enterStby;
    wire        wakeTake = resume & gie_r;
    wire        vecHw    = hwTake | wakeTake;
    // Vectoring wins over an enable in the same cycle, so a taken
    // interrupt never leaves nesting open by accident
    wire        gie_nxt  =
        timeout                     ? 1'b0 :
        (swInt | vecHw)             ? 1'b0 :
        (cmdEnableInt | cmdRetIntr) ? 1'b1 :
        cmdDisableInt               ? 1'b0 : gie_r;
    wire [2:0]  flagClr  = wrIntf ? ~wd[2:0] : 3'h0;
    wire [2:0]  irqFlag_nxt = irqEvt | (irqFlag_r & ~flagClr);

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strapDone_r <= 1'b0;
            cfgWdtEn_r  <= 1'b0;
            cfgWdtPer_r <= 2'd0;
            cfgDiv4_r   <= 1'b0;
            cfgHigh_r   <= 1'b1;
        end else if (!strapDone_r) begin
            strapDone_r <= 1'b1;
            cfgWdtEn_r  <= cfgWdtEnable;
            cfgWdtPer_r <= cfgWdtPeriod;
            cfgDiv4_r   <= cfgInstDiv4;
            cfgHigh_r   <= cfgStartHigh;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hcs_r       <= 1'b1;
            oscStop_r   <= 1'b0;
            modeField_r <= pmwic_pkg::MODE_NORMAL;
        end else if (!strapDone_r || timeout) begin
            hcs_r       <= strapDone_r ? cfgHigh_r : cfgStartHigh;
            oscStop_r   <= 1'b0;
            modeField_r <= pmwic_pkg::MODE_NORMAL;
        end else if (wrOsc && running) begin
            hcs_r       <= wd[pmwic_pkg::OSC_HCS];
            oscStop_r   <= wd[pmwic_pkg::OSC_STOP];
            if (wdMode != 2'h3) begin
                modeField_r <= wdMode;
            end
        end else if (resume) begin
            modeField_r <= pmwic_pkg::MODE_NORMAL;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdtRun_r   <= pmwic_pkg::WDT_RUN_RST;
            extSel_r   <= 1'b0;
            extEdge_r  <= 1'b0;
            irqEn_r    <= pmwic_pkg::INTERRUPT_ENABLE_REG_RST;
            psAssign_r <= 1'b0;
            psSel_r    <= pmwic_pkg::PSSEL_RST;
            wakeSel_r  <= pmwic_pkg::WAKE_RST;
        end else if (timeout) begin
            wdtRun_r   <= pmwic_pkg::WDT_RUN_RST;
            extSel_r   <= 1'b0;
            extEdge_r  <= 1'b0;
            irqEn_r    <= pmwic_pkg::INTERRUPT_ENABLE_REG_RST;
            psAssign_r <= 1'b0;
            psSel_r    <= pmwic_pkg::PSSEL_RST;
            wakeSel_r  <= pmwic_pkg::WAKE_RST;
        end else begin
            if (wrPcon) begin
                wdtRun_r  <= wd[pmwic_pkg::PC_WDT_RUN];
                extSel_r  <= wd[pmwic_pkg::PC_EXT_SEL];
                extEdge_r <= wd[pmwic_pkg::PC_EXT_EDGE];
            end
            if (wrInte) begin
                irqEn_r <= wd[2:0];
            end
            if (wrPscl) begin
                psAssign_r <= wd[pmwic_pkg::PS_ASSIGN];
                psSel_r    <= wd[2:0];
            end
            if (wrWake) begin
                wakeSel_r <= wd[5:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toFlag_r <= 1'b1;
            pdFlag_r <= 1'b1;
        end else if (timeout) begin
            toFlag_r <= 1'b0;
        end else if (enterHalt) begin
            toFlag_r <= 1'b1;
            pdFlag_r <= 1'b0;
        end else if (cmdWdtClear) begin
            toFlag_r <= 1'b1;
            pdFlag_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r   <= pmwic_pkg::ST_NORMAL;
            waitCnt_r <= 5'd0;
            gie_r     <= 1'b0;
            irqFlag_r <= 3'h0;
            wdtCnt_r  <= 32'd0;
            psCnt_r   <= 8'h00;
        end else begin
            state_r   <= strapDone_r ? state_nxt :
                         (cfgStartHigh ? pmwic_pkg::ST_NORMAL
                                       : pmwic_pkg::ST_SLOW);
            waitCnt_r <= (state_r == pmwic_pkg::ST_WAKE) ?
                         waitCnt_r + 5'd1 : 5'd0;
            gie_r     <= gie_nxt;
            irqFlag_r <= timeout ? 3'h0 : irqFlag_nxt;
            wdtCnt_r  <= wdtCnt_nxt;
            psCnt_r   <= psCnt_nxt;
        end
    end

    // Two-flop synchroniser, then a history stage for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinMeta_r <= 6'h00;
            pinSync_r <= 6'h00;
            pinPrev_r <= 6'h00;
        end else begin
            pinMeta_r <= portPin;
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    wire [1:0] instLast = cfgDiv4_r ? 2'd3 : 2'd1;
    wire       instWrap = running & (instDiv_r == instLast);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instDiv_r     <= 2'd0;
            instTick      <= 1'b0;
            cpuRun        <= 1'b0;
            sysClkHigh    <= 1'b1;
            fastOscOn     <= 1'b1;
            slowOscOn     <= 1'b1;
            timerAllow    <= 1'b0;
            wdtResetPulse <= 1'b0;
            vecStrobe     <= 1'b0;
            vecAddr       <= 9'h000;
        end else begin
            instDiv_r     <= (instWrap | ~running) ? 2'd0 : instDiv_r + 2'd1;
            instTick      <= instWrap;
            cpuRun        <= running & strapDone_r;
            sysClkHigh    <= hcs_r;
            // Fast oscillator stays up in Standby unless stopped by firmware
            fastOscOn     <= ~oscStop_r & ~(state_r == pmwic_pkg::ST_HALT);
            slowOscOn     <= ~(state_r == pmwic_pkg::ST_HALT);
            timerAllow    <= running | (state_r == pmwic_pkg::ST_STBY);
            wdtResetPulse <= timeout;
            vecStrobe     <= swInt | vecHw;
            if (swInt) begin
                vecAddr <= pmwic_pkg::VEC_SOFT;
            end else if (vecHw) begin
                vecAddr <= pmwic_pkg::VEC_HW;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitReq_r  <= 1'b1;
            readData_r <= 32'h0000_0000;
        end else begin
            waitReq_r  <= waitReq_nxt;
            if (avsRead && waitReq_r) begin
                readData_r <= {24'h00_0000, rdSel};
            end
        end
    end

    assign avsWaitRequest = waitReq_r;
    assign avsReadData    = readData_r;

endmodule

// ---- tb/pmwic_cpu_model.sv ----
`timescale 1ns/1ps
// ****************
// CPU instruction issue
// ****************
module pmwic_cpu_model (
    input  wire logic       clk,
    input  wire logic       opValid,
    input  wire logic [2:0] opCode,
    output logic      [5:0] cmdPulse
);
    logic [2:0] lastOp_r;
    logic       lastValid_r;
    // Return straight after enable could lose a flag, so it is never issued
    wire        hazard = lastValid_r && lastOp_r == 3'h1 && opCode == 3'h3;
    assign cmdPulse = (opValid && !hazard) ? 6'(6'h01 << opCode) : 6'h00;
    always_ff @(posedge clk) begin
        lastOp_r <= opCode;
        lastValid_r <= opValid;
    end
endmodule

// ---- tb/pmwic_top_properties.sv ----
`timescale 1ns/1ps
// ****************
// Port-level checks
// ****************
module pmwic_top_properties (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       avsRead,
    input wire logic       avsWrite,
    input wire logic       avsWaitRequest,
    input wire logic       cfgInstDiv4,
    input wire logic       cmdSoftInt,
    input wire logic       cmdSleep,
    input wire logic       vecStrobe,
    input wire logic [8:0] vecAddr,
    input wire logic       cpuRun,
    input wire logic       instTick,
    input wire logic       fastOscOn,
    input wire logic       slowOscOn,
    input wire logic       timerAllow,
    input wire logic       wdtResetPulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Halt time is counted so that a resume without settling shows up
    logic [15:0] offCnt_r;
    logic        halted_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            offCnt_r <= 16'h0000;
            halted_r <= 1'b0;
        end else begin
            offCnt_r <= cpuRun ? 16'h0000 : offCnt_r + 16'h0001;
            halted_r <= !cpuRun && (halted_r || !slowOscOn);
        end
    end
    bus_answer_a: assert property ((avsRead || avsWrite) &&
        avsWaitRequest |=> !avsWaitRequest ##1 avsWaitRequest) else $error("bus");
    soft_vector_a: assert property (cmdSoftInt && cpuRun |=>
        vecStrobe && vecAddr == 9'h001) else $error("soft vector");
    vec_pulse_a: assert property (vecStrobe |->
        (vecAddr == 9'h001 || vecAddr == 9'h008) ##1 !vecStrobe) else $error("vec");
    tick_div4_a: assert property (instTick && cfgInstDiv4 |=>
        !instTick [*3]) else $error("tick spacing");
    halt_off_a: assert property (!slowOscOn |->
        !fastOscOn && !cpuRun && !timerAllow) else $error("halt clocks");
    sleep_halt_a: assert property (cmdSleep && cpuRun |->
        ##[1:2] !slowOscOn) else $error("sleep");
    wdt_pulse_a: assert property (wdtResetPulse |=>
        !wdtResetPulse [*8]) else $error("wdt pulse");
    halt_settle_a: assert property ($rose(cpuRun) && halted_r |->
        offCnt_r >= 16'h0010) else $error("halt wake early");
    cover property (vecStrobe && vecAddr == 9'h008);
    cover property (wdtResetPulse);
    cover property (halted_r && cpuRun);
endmodule
bind pmwic_top pmwic_top_properties u_props (.clk(clk), .rst(rst),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest),
    .cfgInstDiv4(cfgInstDiv4), .cmdSoftInt(cmdSoftInt), .cmdSleep(cmdSleep),
    .vecStrobe(vecStrobe), .vecAddr(vecAddr), .cpuRun(cpuRun),
    .instTick(instTick), .fastOscOn(fastOscOn), .slowOscOn(slowOscOn),
    .timerAllow(timerAllow), .wdtResetPulse(wdtResetPulse));

// ---- tb/test_power_mode_wdt_interrupt_ctrl.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin failCount++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_power_mode_wdt_interrupt_ctrl;
    logic        clk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
    logic [4:0]  avsAddress = 5'h00;
    logic [31:0] avsWriteData = 32'h0000_0000, avsReadData, v;
    logic [3:0]  avsByteEnable = 4'h1;
    logic        avsWaitRequest, opValid = 1'b0, timerOverflow = 1'b0;
    logic [2:0]  opCode = 3'h0;
    logic [5:0]  cmd, portPin = 6'h00, portIsInput = 6'h3F;
    logic [1:0]  cfgWdtPeriod = 2'h0;
    logic        cfgInstDiv4 = 1'b1, cfgStartHigh = 1'b1;
    logic        vecStrobe, cpuRun, instTick, sysClkHigh, fastOscOn;
    logic        slowOscOn, timerAllow, wdtResetPulse;
    logic [8:0]  vecAddr, e9, vq[$];
    logic [7:0]  e8, rq[$];
    int          failCount = 0, numChecks = 0, cnt, seed = 32'hce9d;
    pmwic_top #(.WDT_CYC_0(200), .WDT_CYC_1(300), .WDT_CYC_2(400),
        .WDT_CYC_3(500)) DUT (.clk(clk), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .cfgWdtEnable(1'b1),
        .cfgWdtPeriod(cfgWdtPeriod), .cfgInstDiv4(cfgInstDiv4),
        .cfgStartHigh(cfgStartHigh),
        .cmdWdtClear(cmd[0]), .cmdEnableInt(cmd[1]), .cmdDisableInt(cmd[2]),
        .cmdRetIntr(cmd[3]), .cmdSoftInt(cmd[4]), .cmdSleep(cmd[5]),
        .timerOverflow(timerOverflow), .portIsInput(portIsInput),
        .portPin(portPin),
        .vecStrobe(vecStrobe), .vecAddr(vecAddr), .cpuRun(cpuRun),
        .instTick(instTick), .sysClkHigh(sysClkHigh), .fastOscOn(fastOscOn),
        .slowOscOn(slowOscOn), .timerAllow(timerAllow),
        .wdtResetPulse(wdtResetPulse));
    pmwic_cpu_model CPU (.clk(clk), .opValid(opValid), .opCode(opCode),
        .cmdPulse(cmd));
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= {24'h00_0000, d};
        avsWrite <= w;
        avsRead <= !w;
        do @(posedge clk); while (avsWaitRequest);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        rq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    // Timer pulse shares the issue slot so no two tasks overlap
    task automatic op(input logic [2:0] k, input logic t);
        @(posedge clk);
        opCode <= k;
        opValid <= !t;
        timerOverflow <= t;
        @(posedge clk);
        opValid <= 1'b0;
        timerOverflow <= 1'b0;
    endtask
    task automatic reportAndStop;
        $display("checks=%0d mismatches=%0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        if (avsRead && !avsWaitRequest) begin
            e8 = rq.pop_front();
            `CHK(avsReadData, {24'h00_0000, e8})
        end
        if (vecStrobe) begin
            e9 = vq.pop_front();
            `CHK(vecAddr, e9)
        end
    end
    initial begin
        #400_000;
        failCount++;
        reportAndStop;
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, 5'h00, 8'h00);
        rd(5'h08, 8'h18);
        rd(5'h1C, 8'h00);
        op(3'h1, 1'b0);
        rd(5'h08, 8'h98);
        op(3'h2, 1'b0);
        rd(5'h08, 8'h18);
        op(3'h1, 1'b0);
        vq.push_back(9'h001);
        op(3'h4, 1'b0);
        rd(5'h08, 8'h18);
        op(3'h0, 1'b1);
        rd(5'h10, 8'h00);
        bus(1'b1, 5'h0C, 8'h01);
        rd(5'h10, 8'h01);
        bus(1'b1, 5'h10, 8'h00);
        rd(5'h10, 8'h00);
        vq.push_back(9'h008);
        op(3'h1, 1'b0);
        op(3'h0, 1'b1);
        rd(5'h08, 8'h18);
        rd(5'h10, 8'h01);
        bus(1'b1, 5'h10, 8'h00);
        op(3'h3, 1'b0);
        rd(5'h08, 8'h98);
        op(3'h2, 1'b0);
        bus(1'b1, 5'h18, 8'h02);
        bus(1'b1, 5'h0C, 8'h06);
        portPin[1] <= 1'b1;
        repeat (5) @(posedge clk);
        rd(5'h10, 8'h02);
        bus(1'b1, 5'h10, 8'h00);
        bus(1'b1, 5'h18, 8'h01);
        bus(1'b1, 5'h00, 8'h60);
        portPin[0] <= 1'b1;
        repeat (5) @(posedge clk);
        rd(5'h10, 8'h04);
        bus(1'b1, 5'h10, 8'h00);
        bus(1'b1, 5'h18, 8'h02);
        op(3'h5, 1'b0);
        repeat (10) @(posedge clk);
        portPin[1] <= 1'b0;
        cnt = 0;
        while (!cpuRun) begin
            @(posedge clk);
            cnt++;
        end
        `CHK(cnt >= 16, 1'b1)
        rd(5'h08, 8'h10);
        bus(1'b1, 5'h10, 8'h00);
        op(3'h1, 1'b0);
        vq.push_back(9'h008);
        bus(1'b1, 5'h04, 8'h09);
        repeat (3) @(posedge clk);
        `CHK({cpuRun, fastOscOn, timerAllow}, 3'b011)
        op(3'h0, 1'b1);
        repeat (4) @(posedge clk);
        `CHK(cpuRun, 1'b1)
        rd(5'h04, 8'h01);
        bus(1'b1, 5'h10, 8'h00);
        bus(1'b1, 5'h04, 8'h00);
        rd(5'h08, 8'h11);
        `CHK(sysClkHigh, 1'b0)
        bus(1'b1, 5'h04, 8'h01);
        rd(5'h08, 8'h10);
        bus(1'b1, 5'h04, 8'h0D);
        rd(5'h08, 8'h10);
        repeat (3) begin
            v = $random(seed);
            bus(1'b1, 5'h18, v[7:0]);
            rd(5'h18, {2'b00, v[5:0]});
        end
        bus(1'b1, 5'h14, 8'h09);
        op(3'h0, 1'b0);
        rd(5'h08, 8'h18);
        bus(1'b1, 5'h00, 8'h80);
        cnt = 0;
        while (!wdtResetPulse) begin
            @(posedge clk);
            cnt++;
        end
        `CHK(cnt > 390 && cnt < 405, 1'b1)
        repeat (2) @(posedge clk);
        rd(5'h00, 8'h80);
        rd(5'h08, 8'h08);
        bus(1'b1, 5'h00, 8'h00);
        rst <= 1'b1;
        {cfgWdtPeriod, cfgInstDiv4, cfgStartHigh, portIsInput} <= 10'h33D;
        @(posedge clk);
        rst <= 1'b0;
        cnt = 0;
        while (!wdtResetPulse) begin
            @(posedge clk);
            cnt++;
        end
        `CHK(cnt > 495 && cnt < 510, 1'b1)
        rd(5'h08, 8'h09);
        bus(1'b1, 5'h18, 8'h02);
        portPin[1] <= 1'b1;
        bus(1'b1, 5'h0C, 8'h02);
        rd(5'h10, 8'h00);
        @(posedge clk iff instTick);
        repeat (2) @(posedge clk);
        `CHK(instTick, 1'b1)
        reportAndStop;
    end
endmodule
